// ---- src/indexed_instruction_exec.sv ----
/*
 * Executes the OR, indexed add, bit set, push-literal and indexed move ops
 * against a private data memory. Instruction words are issued by software
 * writing the instruction register over AXI4-Lite; one word per write.
 */
`timescale 1ns/1ps
module indexed_instruction_exec
	import exec_pkg::*;
#(
	parameter int DEPTH = MEM_BYTES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Write address and data
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address and data
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [7:0] mem [DEPTH];
	logic [31:0] aw_addr_reg, w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_full_reg, w_full_reg;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [7:0] acc_reg, src_data_reg;
	logic [3:0] bank_reg;
	logic [11:0] fp_reg, mem_addr_reg;
	logic ext_en_reg;
	flags_s flags_reg;
	exec_state_e state_reg;

	// Address resolution shared by every file-register op
	function automatic logic [11:0] resolve(input logic acc_bit, input logic [7:0] f,
			input logic ext, input logic [3:0] bank, input logic [11:0] fp);
		if (!acc_bit && ext && f <= INDEX_MAX)
			resolve = fp + {4'h0, f};
		else if (!acc_bit)
			resolve = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HIGH_BANK, f};
		else
			resolve = {bank, f};
	endfunction

	function automatic logic is_indirect(input logic [11:0] addr);
		is_indirect = (addr == INDIRECT_ADDR0) || (addr == INDIRECT_ADDR1)
			|| (addr == INDIRECT_ADDR2);
	endfunction

	function automatic logic mapped(input logic [31:0] addr);
		mapped = (addr[31:8] == 24'h0000_00) && (addr[1:0] == 2'b00) && (addr[7:0] <= OFF_MEM_DATA);
	endfunction

	// Bus write strobes and the instruction word it carries
	wire wr_do = aw_full_reg && w_full_reg && !bvalid_reg;
	wire [7:0] wr_off = aw_addr_reg[7:0];
	wire wr_ok = mapped(aw_addr_reg);
	wire exec_fire = wr_do && wr_ok && wr_off == OFF_INSTR && (|w_strb_reg);
	wire [15:0] instr = w_data_reg[15:0];

	// Decode; nothing else decodes while a move waits for its second word
	wire idle = (state_reg == ST_IDLE);
	wire is_orl = idle && instr[15:8] == OPC_OR_LIT;
	wire is_orf = idle && instr[15:10] == OPC_OR_FILE;
	wire is_add = idle && instr[15:10] == OPC_ADD;
	wire is_bset = idle && instr[15:12] == OPC_BIT_SET;
	wire is_push = idle && instr[15:8] == OPC_PUSH;
	wire is_move1 = idle && instr[15:8] == OPC_MOVE;
	wire is_move2 = !idle && instr[15:12] == OPC_MOVE_2ND;
	wire dest_file = instr[9];

	// Operand addressing and reads
	wire [11:0] file_addr = resolve(instr[8], instr[7:0], ext_en_reg, bank_reg, fp_reg);
	wire [11:0] offs_addr = fp_reg + {5'h00, instr[6:0]};
	wire [7:0] file_data = mem[file_addr];
	wire [7:0] alu_b = is_orl ? instr[7:0] : file_data;
	wire [7:0] alu_res;
	flags_s alu_flags;
	wire [7:0] bit_mask = 8'h01 << instr[11:9];

	alu8 u_alu (
		.a(acc_reg),
		.b(alu_b),
		.op_add(is_add),
		.result(alu_res),
		.flags(alu_flags)
	);

	// Single memory write port: bus data window or executing instruction
	mem_wr_s mwr;
	wire bus_mem_wr = wr_do && wr_ok && wr_off == OFF_MEM_DATA && w_strb_reg[0];
	wire move_store = exec_fire && is_move2 && !is_indirect(offs_addr);
	assign mwr.we = bus_mem_wr || move_store || (exec_fire && (is_push || is_bset
		|| ((is_orf || is_add) && dest_file)));
	assign mwr.addr = bus_mem_wr ? mem_addr_reg : (is_push ? fp_reg
		: (is_move2 ? offs_addr : file_addr));
	assign mwr.data = bus_mem_wr ? w_data_reg[7:0] : is_push ? instr[7:0]
		: is_move2 ? src_data_reg : is_bset ? (file_data | bit_mask) : alu_res;

	always_ff @(posedge clk) begin
		if (mwr.we)
			mem[mwr.addr] <= mwr.data;
	end

	// Read data mux
	wire [7:0] rd_off = s_axi_araddr[7:0];
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_off)
			OFF_CTRL: rd_word[0] = ext_en_reg;
			OFF_ACC: rd_word[7:0] = acc_reg;
			OFF_BANK: rd_word[3:0] = bank_reg;
			OFF_FP: rd_word[11:0] = fp_reg;
			OFF_STATUS: rd_word[8:0] = {!idle, 3'b000, flags_reg};
			OFF_MEM_ADDR: rd_word[11:0] = mem_addr_reg;
			OFF_MEM_DATA: rd_word[7:0] = mem[mem_addr_reg];
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// AXI write channels: each side is held until the response is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			aw_addr_reg <= 32'h0000_0000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg) begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
				w_full_reg <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (wr_do) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// AXI read channel: answer registered one cycle after the address
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rdata_reg <= mapped(s_axi_araddr) ? rd_word : 32'h0000_0000;
			rresp_reg <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Control registers written directly by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_en_reg <= 1'b0;
			bank_reg <= BANK_RESET;
			mem_addr_reg <= 12'h000;
		end else if (wr_do && wr_ok && w_strb_reg[0]) begin
			if (wr_off == OFF_CTRL)
				ext_en_reg <= w_data_reg[0];
			if (wr_off == OFF_BANK)
				bank_reg <= w_data_reg[3:0];
			if (wr_off == OFF_MEM_ADDR && w_strb_reg[1])
				mem_addr_reg <= w_data_reg[11:0];
		end
	end

	// Accumulator, flags and frame pointer: software writes or execution
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= ACC_RESET;
			flags_reg <= '0;
			fp_reg <= FP_RESET;
		end else if (exec_fire) begin
			if (is_orl || (is_orf && !dest_file) || (is_add && !dest_file))
				acc_reg <= alu_res;
			if (is_orl || is_orf) begin
				flags_reg.n <= alu_flags.n;
				flags_reg.z <= alu_flags.z;
			end
			if (is_add)
				flags_reg <= alu_flags;
			if (is_push)
				fp_reg <= fp_reg - 12'h001;
		end else if (wr_do && wr_ok && w_strb_reg[0]) begin
			if (wr_off == OFF_ACC)
				acc_reg <= w_data_reg[7:0];
			if (wr_off == OFF_STATUS)
				flags_reg <= w_data_reg[4:0];
			if (wr_off == OFF_FP && w_strb_reg[1])
				fp_reg <= w_data_reg[11:0];
		end
	end

	// Two-word move: first word captures the source byte, second stores it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			src_data_reg <= 8'h00;
		end else if (exec_fire) begin
			case (state_reg)
				ST_IDLE: if (is_move1) begin
					state_reg <= ST_MOVE_WAIT;
					src_data_reg <= is_indirect(offs_addr) ? 8'h00 : mem[offs_addr];
				end
				ST_MOVE_WAIT: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence move_first_s;
		exec_fire && is_move1;
	endsequence
	sequence move_second_s;
		exec_fire && !idle;
	endsequence

	or_literal_a: assert property (exec_fire && is_orl |=>
		acc_reg == ($past(acc_reg) | $past(instr[7:0])) && flags_reg.ov == $past(flags_reg.ov))
		else $error("or literal result wrong");
	or_file_dest_a: assert property (exec_fire && is_orf && dest_file |=>
		acc_reg == $past(acc_reg) && mem[$past(file_addr)] == $past(acc_reg | file_data))
		else $error("or file destination wrong");
	bank_select_a: assert property (instr[8] |-> file_addr == {bank_reg, instr[7:0]})
		else $error("bank select address wrong");
	indexed_addr_a: assert property (!instr[8] && ext_en_reg && instr[7:0] <= INDEX_MAX
		|-> file_addr == fp_reg + {4'h0, instr[7:0]})
		else $error("indexed address wrong");
	move_flags_a: assert property (move_first_s or move_second_s |=>
		flags_reg == $past(flags_reg))
		else $error("move changed flags");
	move_two_a: assert property (move_first_s |-> !mwr.we ##1
		state_reg == ST_MOVE_WAIT)
		else $error("move did not wait for second word");
	move_nop_a: assert property (move_second_s ##0 is_indirect(offs_addr) |-> !mwr.we)
		else $error("indirect destination written");
	push_fp_a: assert property (exec_fire && is_push |-> mwr.we && mwr.addr == fp_reg ##1
		fp_reg == $past(fp_reg) - 12'h001)
		else $error("push pointer not decremented");
	add_flags_a: assert property (exec_fire && is_add |=> flags_reg.c == $past(alu_flags.c)
		&& flags_reg.z == ($past(alu_res) == 8'h00))
		else $error("add flags wrong");
	neg_flag_a: assert property (exec_fire && (is_orl || is_add) |=>
		flags_reg.n == $past(alu_res[7]))
		else $error("negative flag wrong");
endmodule

// ---- src/exec_pkg.sv ----
/*
 * Constants, register map and carrier types for the indexed instruction
 * executor. Assumes a 32-bit AXI4-Lite master and a single 125 MHz clock.
 */
package exec_pkg;
	localparam int CLK_MHZ = 125;
	localparam int MEM_BYTES = 4096;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INSTR = 8'h04;
	localparam logic [7:0] OFF_ACC = 8'h08;
	localparam logic [7:0] OFF_BANK = 8'h0C;
	localparam logic [7:0] OFF_FP = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_MEM_ADDR = 8'h18;
	localparam logic [7:0] OFF_MEM_DATA = 8'h1C;
	// Status field positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_N = 4;
	localparam int ST_MOVE = 8;
	// Opcodes
	localparam logic [7:0] OPC_OR_LIT = 8'h09;
	localparam logic [5:0] OPC_OR_FILE = 6'h04;
	localparam logic [5:0] OPC_ADD = 6'h09;
	localparam logic [3:0] OPC_BIT_SET = 4'h8;
	localparam logic [7:0] OPC_PUSH = 8'hEA;
	localparam logic [7:0] OPC_MOVE = 8'hEB;
	localparam logic [3:0] OPC_MOVE_2ND = 4'hF;
	// Addressing
	localparam logic [7:0] INDEX_MAX = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [11:0] INDIRECT_ADDR0 = 12'hFE0;
	localparam logic [11:0] INDIRECT_ADDR1 = 12'hFE8;
	localparam logic [11:0] INDIRECT_ADDR2 = 12'hFF0;
	// Reset values and bus response codes
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [3:0] BANK_RESET = 4'h0;
	localparam logic [11:0] FP_RESET = 12'h000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} flags_s;

	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} mem_wr_s;

	typedef enum logic {ST_IDLE, ST_MOVE_WAIT} exec_state_e;
endpackage

// ---- src/alu8.sv ----
/*
 * Eight-bit OR / add unit with status flags.
 * Purely combinational; the caller registers results and flags.
 */
`timescale 1ns/1ps
module alu8
	import exec_pkg::*;
(
	// Operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic op_add,
	// Result
	output logic [7:0] result,
	output flags_s flags
);
	logic [8:0] sum;
	logic [4:0] low_sum;

	// Low nibble sum gives the digit carry, full sum the carry
	assign sum = {1'b0, a} + {1'b0, b};
	assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
	assign result = op_add ? sum[7:0] : (a | b);
	assign flags.n = result[7];
	assign flags.z = (result == 8'h00);
	assign flags.c = sum[8];
	assign flags.dc = low_sum[4];
	// Signed overflow: like-signed operands giving an unlike-signed sum
	assign flags.ov = (a[7] == b[7]) && (sum[7] != a[7]);
endmodule

// ---- verif/indexed_instruction_exec_test.sv ----
/*
 * Self-checking bench for the indexed instruction executor.
 * Assumes the AXI4-Lite register map and instruction encodings of exec_pkg.
 */
`timescale 1ns/1ps
module indexed_instruction_exec_test
	import exec_pkg::*;
();
	// Clock, reset and bus wires
	logic clk, rst_n;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int fails = 0;
	int checks = 0;

	indexed_instruction_exec #(.DEPTH(MEM_BYTES)) dut (.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

	// Free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Write master: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(s_axi_bvalid === 1'b1) && n < 100);
		s_axi_bready <= 1'b0;
		if (n >= 100) fails++;
		check("bresp", 32'(s_axi_bresp), 32'(er));
	endtask

	// Read master: rready held until the data beat is sampled
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
		int n;
		logic ar;
		ar = 1'b1;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (ar && s_axi_arready) begin
				ar = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (!(s_axi_rvalid === 1'b1) && n < 100);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		if (n >= 100) fails++;
		check("rresp", 32'(s_axi_rresp), 32'(er));
	endtask

	// Register, memory and instruction helpers
	task automatic creg(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		check(nm, v, e);
	endtask
	task automatic setm(input logic [11:0] a, input logic [7:0] d);
		wr(OFF_MEM_ADDR, 32'(a));
		wr(OFF_MEM_DATA, 32'(d));
	endtask
	task automatic cmem(input logic [11:0] a, input logic [7:0] e);
		wr(OFF_MEM_ADDR, 32'(a));
		creg("mem", OFF_MEM_DATA, 32'(e));
	endtask
	task automatic ex(input logic [15:0] w);
		wr(OFF_INSTR, 32'(w));
	endtask

	task automatic test_reset();
		logic [31:0] v;
		creg("acc", OFF_ACC, 32'(ACC_RESET));
		creg("fp", OFF_FP, 32'(FP_RESET));
		creg("bank", OFF_BANK, 32'(BANK_RESET));
		creg("status", OFF_STATUS, 32'h0000_0000);
		rd(8'h20, v, RESP_SLVERR);
		check("unmapped", v, 32'h0000_0000);
		wr(8'h20, 32'h0000_00FF, RESP_SLVERR);
		$display("reset test done");
	endtask

	task automatic test_or_lit();
		wr(OFF_STATUS, 32'h0000_000B);
		wr(OFF_ACC, 32'h0000_009A);
		ex(16'h0935);
		creg("acc", OFF_ACC, 32'h0000_00BF);
		creg("status", OFF_STATUS, 32'h0000_001B);
		wr(OFF_ACC, 32'h0000_0000);
		wr(OFF_STATUS, 32'h0000_0000);
		ex(16'h0900);
		creg("status", OFF_STATUS, 32'h0000_0004);
		$display("or literal test done");
	endtask

	task automatic test_or_file();
		wr(OFF_BANK, 32'h0000_0002);
		setm(12'h213, 8'h13);
		wr(OFF_ACC, 32'h0000_0091);
		ex(16'h1113);
		creg("acc", OFF_ACC, 32'h0000_0093);
		creg("status", OFF_STATUS, 32'h0000_0010);
		cmem(12'h213, 8'h13);
		wr(OFF_ACC, 32'h0000_0040);
		ex(16'h1313);
		cmem(12'h213, 8'h53);
		creg("acc", OFF_ACC, 32'h0000_0040);
		setm(12'hF70, 8'h01);
		ex(16'h1070);
		creg("acc", OFF_ACC, 32'h0000_0041);
		$display("or file test done");
	endtask

	task automatic test_add();
		wr(OFF_CTRL, 32'h0000_0001);
		wr(OFF_FP, 32'h0000_0A00);
		setm(12'hA2C, 8'h20);
		wr(OFF_ACC, 32'h0000_0017);
		wr(OFF_STATUS, 32'h0000_0000);
		ex(16'h242C);
		creg("acc", OFF_ACC, 32'h0000_0037);
		setm(12'hA2C, 8'h80);
		wr(OFF_ACC, 32'h0000_0080);
		ex(16'h262C);
		cmem(12'hA2C, 8'h00);
		creg("status", OFF_STATUS, 32'h0000_000D);
		// Edge of the indexed window: 5Fh is indexed, 60h falls back to the access bank
		setm(12'hA5F, 8'h05);
		setm(12'hF60, 8'h01);
		wr(OFF_ACC, 32'h0000_0002);
		ex(16'h245F);
		creg("acc", OFF_ACC, 32'h0000_0007);
		ex(16'h2460);
		creg("acc", OFF_ACC, 32'h0000_0008);
		// Bit set on an indexed byte: bit 7 of 55h gives D5h
		setm(12'hA0A, 8'h55);
		ex(16'h8E0A);
		cmem(12'hA0A, 8'hD5);
		$display("indexed add test done");
	endtask

	task automatic test_push();
		wr(OFF_STATUS, 32'h0000_001F);
		wr(OFF_FP, 32'h0000_01EC);
		ex(16'hEA08);
		cmem(12'h1EC, 8'h08);
		creg("fp", OFF_FP, 32'h0000_01EB);
		creg("status", OFF_STATUS, 32'h0000_001F);
		wr(OFF_FP, 32'h0000_0000);
		ex(16'hEAFF);
		cmem(12'h000, 8'hFF);
		creg("fp", OFF_FP, 32'h0000_0FFF);
		$display("push test done");
	endtask

	task automatic test_move();
		wr(OFF_FP, 32'h0000_0080);
		setm(12'h085, 8'h33);
		setm(12'h086, 8'h11);
		wr(OFF_STATUS, 32'h0000_0000);
		ex(16'hEB85);
		creg("status", OFF_STATUS, 32'h0000_0100);
		ex(16'hF006);
		cmem(12'h086, 8'h33);
		creg("status", OFF_STATUS, 32'h0000_0000);
		// Largest offset, wrapping past the top of the data space
		wr(OFF_FP, 32'h0000_0FA0);
		setm(12'h01F, 8'h44);
		ex(16'hEBFF);
		ex(16'hF000);
		cmem(12'hFA0, 8'h44);
		// Indirect source yields zero, indirect destination does nothing
		wr(OFF_FP, 32'h0000_0FD0);
		setm(12'hFE0, 8'h77);
		setm(12'hFD1, 8'h11);
		ex(16'hEB90);
		ex(16'hF001);
		cmem(12'hFD1, 8'h00);
		setm(12'hFE8, 8'h5A);
		setm(12'hFD2, 8'h66);
		ex(16'hEB82);
		ex(16'hF018);
		cmem(12'hFE8, 8'h5A);
		// A word that is not a second move word cancels the move and is not run
		wr(OFF_ACC, 32'h0000_0000);
		ex(16'hEB85);
		ex(16'h0935);
		creg("acc", OFF_ACC, 32'h0000_0000);
		creg("status", OFF_STATUS, 32'h0000_0000);
		$display("indexed move test done");
	endtask

	// Hang guard, well beyond the few hundred cycles the tests need
	initial begin
		#100_000;
		fails++;
		give_verdict();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		test_reset();
		test_or_lit();
		test_or_file();
		test_add();
		test_push();
		test_move();
		give_verdict();
	end
endmodule
